// ==== hw/srp_consts.svh ====
`ifndef SRP_CONSTS_SVH
`define SRP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------------------
`define SRP_INSTR_LAST_BIT 4'h0F
`define SRP_INSTR_RD_BIT   15
`define SRP_INSTR_LEN_HI   14
`define SRP_INSTR_LEN_LO   13
`define SRP_INSTR_ADDR_HI  7
`define SRP_BYTE_LAST_BIT  3'h7
`define SRP_LEN_STREAM     2'h3

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SRP_ADDR_CFG       8'h00
`define SRP_ADDR_ADC_SEL   8'h05
`define SRP_ADDR_CM_BUF    8'h0F
`define SRP_ADDR_ADC_OFS   8'h10
`define SRP_ADDR_UPDATE    8'hFF
`define SRP_ADDR_STOP      8'hFF

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SRP_CFG_RESET      8'h18
`define SRP_CFG_IN_ONLY    7
`define SRP_CFG_LSB_HI     6
`define SRP_CFG_SRST       5
`define SRP_CFG_LSB_LO     2
`define SRP_SEL_RESET      2'h0
`define SRP_SEL_Q_ONLY     2'h2
`define SRP_CM_BIT         1
`define SRP_OFS_HI         5
`define SRP_UPD_BIT        0

`endif

// ==== hw/srp_pkg.sv ====
package srp_pkg;

  // Serial port sequencer states.
  typedef enum logic [1:0]
  {
    srp_st_instr = 2'b00,
    srp_st_data  = 2'b01,
    srp_st_done  = 2'b10
  } srp_state_e;

  // Active converter controls, written indirectly through the update register.
  typedef struct packed
  {
    logic       cm_q;
    logic       cm_i;
    logic [5:0] off_q;
    logic [5:0] off_i;
  } srp_adc_ctrl_s;

endpackage

// ==== hw/srp_word_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// Carries a held word from the serial clock domain into the system domain.
// The source keeps the word stable after each load, and loads are at least
// one byte of serial clocks apart, so a toggle handshake without return is safe.
module srp_word_sync
  import srp_pkg::*;
(
  // Source side
  input  wire logic          src_clk,
  input  wire logic          src_rst,
  input  wire logic          src_load,
  input  wire srp_pkg::srp_adc_ctrl_s src_word,
  // Destination side
  input  wire logic          dst_clk,
  input  wire logic          dst_rst,
  output srp_pkg::srp_adc_ctrl_s dst_word
);

  logic          tgl_r;
  logic          meta_r;
  logic          sync_r;
  logic          seen_r;
  srp_adc_ctrl_s word_r;
  wire           fresh = sync_r ^ seen_r;

  // The toggle flips in the same edge that changes the held word.
  always_ff @(posedge src_clk or posedge src_rst)
  begin
    if (src_rst)
      tgl_r <= 1'b0;
    else if (src_load)
      tgl_r <= ~tgl_r;
  end

  // Two flops bring the toggle over; only the second one is looked at.
  always_ff @(posedge dst_clk or posedge dst_rst)
  begin
    if (dst_rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else
    begin
      meta_r <= tgl_r;
      sync_r <= meta_r;
      seen_r <= sync_r;
    end
  end

  // The word has been stable for two destination cycles when it is taken.
  always_ff @(posedge dst_clk or posedge dst_rst)
  begin
    if (dst_rst)
      word_r <= '0;
    else if (fresh)
      word_r <= src_word;
  end

  assign dst_word = word_r;

endmodule

`default_nettype wire

// ==== hw/srp_serial_port.sv ====
// Operation
// - A transfer opens with a 16-bit instruction on the first sixteen rising clocks.
// - Instruction top bit is read or write, then two length bits, then address.
// - Length code 00, 01, 10 gives one to three bytes; 11 streams.
// - With chip select high the data line floats and the clock is ignored.
// - Write data bits are sampled on the rising serial clock edge.
// - Transfer length is one, two, three bytes or streaming, per length code.
// - A read of N bytes shifts out N times eight bits from the address.
// - Streaming reads return every successive register until chip select rises or the byte at address 0xFF is read.
// - Read data is driven so it is valid at the falling clock edge.
// - Default order is most significant bit first for instruction and data.
// - Most significant first: address decrements after each data byte.
// - Least significant first: bits go bottom first, address increments.
// - Bit order change in configuration bits 2 and 6 acts at once.
// - Fixed-length transfers end by themselves after their data clocks.
// - Chip select high on a byte boundary of a fixed-length transfer stalls; low again resumes.
// - Chip select rising mid-byte resets the port sequencer.
// - Streaming ends on chip select rising or when address reaches 0xFF.
// - Stop runs up to 0xFF, or down through 0x00, wraps to 0xFF, stops.
// - Registers 0x0F and 0x10 are written via select, target, then update.
// - Select value 0x03 addresses both converters for indirect writes.
// - Writing 0x01 to the update register makes pending values active.
`timescale 1ns/1ps
`default_nettype none
`include "srp_consts.svh"

module srp_serial_port
(
  // System clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Serial link
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdio_in,
  output logic                   sdio_out,
  output logic                   sdio_oe,
  // Converter controls in the system domain
  output srp_pkg::srp_adc_ctrl_s adc_ctrl
);

  import srp_pkg::*;

  // --------------------------------------------------------------------------
  // Link state
  // --------------------------------------------------------------------------
  srp_state_e    state_r;
  srp_state_e    state_nxt;
  logic [3:0]    bit_cnt_r;
  logic [3:0]    bit_cnt_nxt;
  logic [15:0]   sh_r;
  logic          rd_r;
  logic [1:0]    len_r;
  logic [7:0]    addr_r;
  logic [1:0]    byte_cnt_r;
  logic          gap_r;
  logic          sdio_out_r;
  logic          sdio_oe_r;
  logic [7:0]    cfg_r;
  logic [1:0]    sel_r;
  logic [1:0]    pend_cm_r;
  logic [5:0]    pend_off_i_r;
  logic [5:0]    pend_off_q_r;
  srp_adc_ctrl_s ctrl_r;

  // Address compare, shared by the read mux and the write decode.
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    addr_is = (a == b);
  endfunction

  // --------------------------------------------------------------------------
  // Framing and bit order
  // --------------------------------------------------------------------------
  // A frame gap mid-byte, after a finished transfer or inside a stream means the
  // next clock is bit 0 of a new instruction; on a byte boundary it is a stall.
  wire        live       = ~cs_n;
  wire        stream     = (len_r == `SRP_LEN_STREAM);
  wire        mid_byte   = (bit_cnt_r[2:0] != 3'h0);
  wire        restart    = gap_r & (mid_byte | (state_r == srp_st_done) |
                                    ((state_r == srp_st_data) & stream));
  wire srp_state_e eff_state = restart ? srp_st_instr : state_r;
  wire [3:0]  eff_cnt    = restart ? 4'h0 : bit_cnt_r;
  // Either mirrored bit selects bottom-first order; read every bit, so a
  // change lands on the next bit of the same transfer.
  wire        lsb_first  = cfg_r[`SRP_CFG_LSB_HI] | cfg_r[`SRP_CFG_LSB_LO];
  wire [15:0] sh_nxt     = lsb_first ? {sdio_in, sh_r[15:1]} : {sh_r[14:0], sdio_in};

  // --------------------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------------------
  wire        instr_done = (eff_state == srp_st_instr) & (eff_cnt == `SRP_INSTR_LAST_BIT);
  wire        instr_rd   = sh_nxt[`SRP_INSTR_RD_BIT];
  wire [1:0]  instr_len  = sh_nxt[`SRP_INSTR_LEN_HI:`SRP_INSTR_LEN_LO];
  // Upper address bits are expected zero and are not decoded.
  wire [7:0]  instr_addr = sh_nxt[`SRP_INSTR_ADDR_HI:0];

  // --------------------------------------------------------------------------
  // Data phase decode
  // --------------------------------------------------------------------------
  wire        in_data    = (eff_state == srp_st_data);
  wire        byte_done  = in_data & (eff_cnt[2:0] == `SRP_BYTE_LAST_BIT);
  wire        last_byte  = stream ? addr_is(addr_r, `SRP_ADDR_STOP) : (byte_cnt_r == len_r);
  wire [7:0]  addr_step  = lsb_first ? 8'(addr_r + 8'h01) : 8'(addr_r - 8'h01);
  wire [7:0]  wr_byte    = lsb_first ? sh_nxt[15:8] : sh_nxt[7:0];
  wire        wr_en      = live & byte_done & ~rd_r;
  wire        hit_cfg    = addr_is(addr_r, `SRP_ADDR_CFG);
  wire        hit_sel    = addr_is(addr_r, `SRP_ADDR_ADC_SEL);
  wire        hit_cm     = addr_is(addr_r, `SRP_ADDR_CM_BUF);
  wire        hit_ofs    = addr_is(addr_r, `SRP_ADDR_ADC_OFS);
  wire        hit_upd    = addr_is(addr_r, `SRP_ADDR_UPDATE);
  wire        soft_rst   = wr_en & hit_cfg & ~cfg_r[`SRP_CFG_SRST] & wr_byte[`SRP_CFG_SRST];
  wire        do_update  = wr_en & hit_upd & wr_byte[`SRP_UPD_BIT];
  wire srp_adc_ctrl_s pend_w = '{cm_q: pend_cm_r[1], cm_i: pend_cm_r[0],
                                 off_q: pend_off_q_r, off_i: pend_off_i_r};

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Converter registers read back the active value of the first addressed
  // converter; unmapped and update addresses read as zero.
  wire        q_only     = (sel_r == `SRP_SEL_Q_ONLY);
  wire        rd_cm      = q_only ? ctrl_r.cm_q : ctrl_r.cm_i;
  wire [5:0]  rd_off     = q_only ? ctrl_r.off_q : ctrl_r.off_i;
  wire [7:0]  rd_byte    = hit_cfg ? cfg_r :
                           hit_sel ? {6'h00, sel_r} :
                           hit_cm  ? {6'h00, rd_cm, 1'b0} :
                           hit_ofs ? {2'h0, rd_off} : 8'h00;
  wire [2:0]  rd_idx     = lsb_first ? eff_cnt[2:0] : 3'(`SRP_BYTE_LAST_BIT - eff_cnt[2:0]);
  wire        rd_bit     = rd_byte[rd_idx];
  wire        drive      = in_data & rd_r & ~cfg_r[`SRP_CFG_IN_ONLY];

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb
  begin
    state_nxt   = eff_state;
    bit_cnt_nxt = 4'(eff_cnt + 4'h1);
    unique case (eff_state)
      srp_st_instr:
      begin
        if (instr_done)
        begin
          state_nxt   = srp_st_data;
          bit_cnt_nxt = 4'h0;
        end
      end
      srp_st_data:
      begin
        bit_cnt_nxt = {1'b0, 3'(eff_cnt[2:0] + 3'h1)};
        if (byte_done & last_byte)
          state_nxt = srp_st_done;
      end
      srp_st_done:
        bit_cnt_nxt = 4'h0;
      default:
      begin
        state_nxt   = srp_st_instr;
        bit_cnt_nxt = 4'h0;
      end
    endcase
  end

  // Clocks seen while chip select is high are ignored.
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r   <= srp_st_instr;
      bit_cnt_r <= 4'h0;
      sh_r      <= 16'h0000;
    end
    else if (live)
    begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      sh_r      <= sh_nxt;
    end
  end

  // Instruction fields and the address generator.
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_r       <= 1'b0;
      len_r      <= 2'h0;
      addr_r     <= 8'h00;
      byte_cnt_r <= 2'h0;
    end
    else if (live & instr_done)
    begin
      rd_r       <= instr_rd;
      len_r      <= instr_len;
      addr_r     <= instr_addr;
      byte_cnt_r <= 2'h0;
    end
    else if (live & byte_done)
    begin
      addr_r     <= addr_step;
      byte_cnt_r <= 2'(byte_cnt_r + 2'h1);
    end
  end

  // Remembers that chip select went high since the last clock.
  always_ff @(posedge sclk or posedge cs_n or posedge sys_rst)
  begin
    if (sys_rst | cs_n)
      gap_r <= 1'b1;
    else
      gap_r <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Line driver
  // --------------------------------------------------------------------------
  // Each bit goes out on a rising edge and holds through the falling edge the
  // host samples on; chip select high releases the line without a clock.
  always_ff @(posedge sclk or posedge cs_n or posedge sys_rst)
  begin
    if (sys_rst | cs_n)
    begin
      sdio_oe_r  <= 1'b0;
      sdio_out_r <= 1'b0;
    end
    else
    begin
      sdio_oe_r  <= drive;
      sdio_out_r <= drive & rd_bit;
    end
  end

  assign sdio_out = sdio_out_r;
  assign sdio_oe  = sdio_oe_r;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  // The mirrored reset value keeps order switches harmless.
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_r <= `SRP_CFG_RESET;
    else if (wr_en & hit_cfg)
      cfg_r <= wr_byte;
  end

  // Pending converter values land only in the converters selected.
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_r        <= `SRP_SEL_RESET;
      pend_cm_r    <= 2'h0;
      pend_off_i_r <= 6'h00;
      pend_off_q_r <= 6'h00;
    end
    else if (soft_rst)
    begin
      sel_r        <= `SRP_SEL_RESET;
      pend_cm_r    <= 2'h0;
      pend_off_i_r <= 6'h00;
      pend_off_q_r <= 6'h00;
    end
    else if (wr_en)
    begin
      if (hit_sel)
        sel_r <= wr_byte[1:0];
      for (int i = 0; i < 2; i++)
      begin
        if (hit_cm & sel_r[i])
          pend_cm_r[i] <= wr_byte[`SRP_CM_BIT];
      end
      if (hit_ofs & sel_r[0])
        pend_off_i_r <= wr_byte[`SRP_OFS_HI:0];
      if (hit_ofs & sel_r[1])
        pend_off_q_r <= wr_byte[`SRP_OFS_HI:0];
    end
  end

  // Active values change only on an update write or a soft reset, so the converters
  // never see a half-written pair.
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_r <= '0;
    else if (soft_rst)
      ctrl_r <= '0;
    else if (do_update)
      ctrl_r <= pend_w;
  end

  // --------------------------------------------------------------------------
  // Crossing to the system domain
  // --------------------------------------------------------------------------
  // The toggle flips on the edge that loads the active value, and the word handed
  // over is that same value, so no serial clock is needed after the update byte.
  // The host must leave at least a byte of clocks between two updates.
  wire srp_adc_ctrl_s pend_sel_w = soft_rst ? srp_adc_ctrl_s'('0) : pend_w;

  srp_word_sync u_word_sync
  (
    .src_clk  (sclk),
    .src_rst  (sys_rst),
    .src_load (live & (soft_rst | do_update)),
    .src_word (pend_sel_w),
    .dst_clk  (sys_clk),
    .dst_rst  (sys_rst),
    .dst_word (adc_ctrl)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb_link @(posedge sclk);
  endclocking
  default disable iff (sys_rst);

  sequence seq_instr_end;
    live && instr_done;
  endsequence

  sequence seq_byte_end;
    live && byte_done;
  endsequence

  chk_instr_to_data: assert property (seq_instr_end |=> state_r == srp_st_data && bit_cnt_r == 4'h0)
    else $error("instruction phase did not end after sixteen bits");

  chk_instr_fields: assert property (seq_instr_end |=> rd_r == $past(instr_rd) && len_r == $past(instr_len) && addr_r == $past(instr_addr))
    else $error("instruction fields not latched");

  chk_addr_step: assert property ((seq_byte_end ##0 !last_byte) |=> addr_r == ($past(lsb_first) ? 8'($past(addr_r) + 8'h01) : 8'($past(addr_r) - 8'h01)))
    else $error("address did not step after a data byte");

  chk_fixed_end: assert property ((seq_byte_end ##0 (!stream && byte_cnt_r == len_r)) |=> state_r == srp_st_done)
    else $error("fixed transfer did not end on its last byte");

  chk_stream_stop: assert property ((seq_byte_end ##0 (stream && addr_r == `SRP_ADDR_STOP)) |=> state_r == srp_st_done)
    else $error("stream did not stop at the top address");

  chk_mid_byte_reset: assert property ((live && gap_r && mid_byte) |=> state_r == srp_st_instr && bit_cnt_r == 4'h1)
    else $error("mid-byte gap did not restart the sequencer");

  chk_read_drive: assert property ((live && drive) |=> gap_r || (sdio_oe_r && sdio_out_r == $past(rd_bit)))
    else $error("read bit not driven");

  chk_oe_read_only: assert property (sdio_oe_r |-> rd_r && state_r != srp_st_instr)
    else $error("line driven outside a read data phase");

  chk_update_copy: assert property ((wr_en && hit_upd && wr_byte[`SRP_UPD_BIT] && !soft_rst) |=> ctrl_r == $past(pend_w))
    else $error("update write did not load the active controls");

  chk_cfg_write: assert property ((wr_en && hit_cfg) |=> cfg_r == $past(wr_byte))
    else $error("configuration write lost");

  chk_cs_idle: assert property (@(posedge sys_clk) disable iff (sys_rst) cs_n |-> !sdio_oe)
    else $error("data line driven while deselected");

endmodule

`default_nettype wire

// ==== verification/srp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// --------------------
// Serial master model
// --------------------
// Stands in the host's place. Its clock runs only inside frames.
module srp_host_model
(
  // Serial link
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_line,
  input  wire logic sdio_out,
  input  wire logic sdio_oe
);
  logic        lclk;
  logic        gate;
  logic        drv_en;
  logic        drv_bit;
  logic [63:0] got;
  logic [63:0] got_oe;

  // Free link clock, 32 ns, phase unrelated to the system clock.
  initial
  begin
    lclk = 1'b0;
    cs_n = 1'b1;
    gate = 1'b0;
    drv_en = 1'b1;
    drv_bit = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end

  // The gate only moves while lclk is low, so sclk never glitches.
  assign sclk = lclk & gate;
  // A released line shows the inverse of the last bit, so a stale value cannot pass.
  assign sdio_line = sdio_oe ? sdio_out : (drv_en ? drv_bit : ~drv_bit);

  // Chip select moves only while the link clock is low.
  task automatic select(input logic lvl);
    @(negedge lclk);
    cs_n = lvl;
  endtask

  // Shifts n bits, v[n-1] first; the line is let go from bit rel on.
  // Each bit is sampled at the falling edge after its rising edge.
  task automatic shift(input logic [63:0] v, input int n, input int rel);
    for (int i = 0; i < n; i++)
    begin
      @(negedge lclk);
      if (i > 0)
      begin
        got = {got[62:0], sdio_line};
        got_oe = {got_oe[62:0], sdio_oe};
      end
      drv_en = (i < rel);
      drv_bit = v[n - 1 - i];
      gate = 1'b1;
    end
    @(negedge lclk);
    got = {got[62:0], sdio_line};
    got_oe = {got_oe[62:0], sdio_oe};
    gate = 1'b0;
    drv_en = 1'b1;
  endtask
endmodule

`default_nettype wire

// ==== verification/serial_register_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module serial_register_port_tb;
  import srp_pkg::*;
  // --------------------
  // Device and link
  // --------------------
  logic          sys_clk;
  logic          sys_rst;
  logic          sclk;
  logic          cs_n;
  logic          sdio_line;
  logic          sdio_out;
  logic          sdio_oe;
  srp_adc_ctrl_s adc_ctrl;
  int            fail_count;
  int            checked;
  logic [7:0]    cfg_m;
  logic [1:0]    sel_m;
  srp_adc_ctrl_s pend_m;
  srp_adc_ctrl_s act_m;
  logic [31:0]   r;
  logic [1:0]    sel_v;

  srp_serial_port dut_u
  (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .sclk     (sclk),
    .cs_n     (cs_n),
    .sdio_in  (sdio_line),
    .sdio_out (sdio_out),
    .sdio_oe  (sdio_oe),
    .adc_ctrl (adc_ctrl)
  );
  srp_host_model host_u
  (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .sdio_line (sdio_line),
    .sdio_out  (sdio_out),
    .sdio_oe   (sdio_oe)
  );

  // System clock, 5 ns.
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // --------------------
  // Reference model
  // --------------------
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      rev8[i] = b[7 - i];
  endfunction

  function automatic logic [7:0] mread(input logic [7:0] a);
    case (a)
      8'h00: return cfg_m;
      8'h0F: return {6'h00, sel_m == 2'h2 ? act_m.cm_q : act_m.cm_i, 1'b0};
      8'h10: return {2'h0, sel_m == 2'h2 ? act_m.off_q : act_m.off_i};
      default: return 8'h00;
    endcase
  endfunction

  // Indirect writes land in the pending copy of every selected converter.
  task automatic mwrite(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h00 && !cfg_m[5] && d[5])
    begin
      sel_m = 2'h0;
      pend_m = '0;
      act_m = '0;
    end
    if (a == 8'h00) cfg_m = d;
    if (a == 8'h05) sel_m = d[1:0];
    if (a == 8'h0F && sel_m[0]) pend_m.cm_i = d[1];
    if (a == 8'h0F && sel_m[1]) pend_m.cm_q = d[1];
    if (a == 8'h10 && sel_m[0]) pend_m.off_i = d[5:0];
    if (a == 8'h10 && sel_m[1]) pend_m.off_q = d[5:0];
    if (a == 8'hFF && d[0]) act_m = pend_m;
  endtask

  // One frame; wd holds the data bytes in time order from its top byte.
  task automatic xfer(input bit rd, input logic [1:0] len, input logic [7:0] adr,
                      input logic [31:0] wd, input int n, input bit stall);
    logic [63:0] v;
    logic [31:0] exp_oe;
    logic [31:0] msk;
    logic [7:0]  exp_rd [4];
    logic [7:0]  adrs [4];
    logic [15:0] ins;
    logic [7:0]  a;
    logic [7:0]  b;
    bit          live;
    bit          lsb;
    live = 1'b1;
    a = adr;
    v = '0;
    exp_oe = '0;
    msk = 32'hFFFF_FFFF >> (32 - 8 * n);
    lsb = cfg_m[6] | cfg_m[2];
    ins = {rd, len, 5'h00, adr};
    if (lsb) ins = {rev8(ins[7:0]), rev8(ins[15:8])};
    for (int k = 0; k < n; k++)
    begin
      b = wd[31 - 8 * k -: 8];
      v = {v[55:0], lsb ? rev8(b) : b};
      exp_oe = {exp_oe[23:0], {8{rd & live}}};
      exp_rd[k] = mread(a);
      adrs[k] = a;
      if (live && !rd) mwrite(a, b);
      live = live & ((len == 2'h3) ? (a != 8'hFF) : (k < len));
      a = lsb ? a + 8'h01 : a - 8'h01;
    end
    host_u.select(1'b0);
    host_u.shift({48'h0, ins}, 16, 64);
    if (stall)
    begin
      host_u.select(1'b1);
      host_u.select(1'b0);
    end
    host_u.shift(v, 8 * n, rd ? 0 : 64);
    for (int k = 0; k < n; k++)
    begin
      b = host_u.got[8 * (n - 1 - k) +: 8];
      if (lsb) b = rev8(b);
      if (exp_oe[8 * (n - 1 - k)] && adrs[k] != 8'hFF)
        `CHK("read data", exp_rd[k], b)
    end
    `CHK("drive window", exp_oe, host_u.got_oe[31:0] & msk)
    host_u.select(1'b1);
    #1;
    `CHK("idle release", 1'b0, sdio_oe)
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard: well past the longest sequence.
  initial
  begin
    #400000;
    fail_count++;
    summarize();
  end

  // --------------------
  // Main sequence
  // --------------------
  initial
  begin
    fail_count = 0;
    checked = 0;
    sys_rst = 1'b1;
    cfg_m = 8'h18;
    sel_m = 2'h0;
    pend_m = '0;
    act_m = '0;
    void'($urandom(49));
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    xfer(1, 2'h0, 8'h00, 32'h0, 1, 0);
    `CHK("adc_ctrl reset", act_m, adc_ctrl)
    // Abort mid-byte, then the port must take a fresh instruction.
    host_u.select(1'b0);
    host_u.shift(64'h0000_000F, 20, 64);
    host_u.select(1'b1);
    xfer(1, 2'h0, 8'h00, 32'h0, 1, 0);
    // Indirect writes to random converter sets.
    repeat (4)
    begin
      r = $urandom;
      sel_v = (r[1:0] == 2'h0) ? 2'h3 : r[1:0];
      xfer(0, 2'h0, 8'h05, {6'h00, sel_v, 24'h0}, 1, 0);
      xfer(0, 2'h1, 8'h10, {2'h0, r[13:8], 6'h00, r[16], 1'b0, 16'h0}, 2, 1);
      repeat (8) @(posedge sys_clk);
      `CHK("adc_ctrl held", act_m, adc_ctrl)
      xfer(0, 2'h0, 8'hFF, 32'h0100_0000, 1, 0);
      repeat (8) @(posedge sys_clk);
      `CHK("adc_ctrl", act_m, adc_ctrl)
      xfer(1, 2'h1, 8'h10, 32'h0, 2, 1);
      xfer(0, 2'h0, 8'h05, 32'h0, 1, 0);
    end
    xfer(1, 2'h3, 8'h01, 32'h0, 4, 0);
    xfer(0, 2'h3, 8'h01, 32'h0018_0000, 3, 0);
    xfer(1, 2'h0, 8'h10, 32'h0, 2, 0);
    xfer(0, 2'h0, 8'h01, 32'h0081_0000, 2, 0);
    xfer(0, 2'h0, 8'h00, 32'h4200_0000, 1, 0);
    xfer(1, 2'h2, 8'h0E, 32'h0, 3, 0);
    xfer(1, 2'h3, 8'hFE, 32'h0, 3, 0);
    xfer(0, 2'h0, 8'h00, 32'h6600_0000, 1, 0);
    repeat (8) @(posedge sys_clk);
    `CHK("adc_ctrl cleared", act_m, adc_ctrl)
    xfer(0, 2'h0, 8'h00, 32'h1800_0000, 1, 0);
    xfer(1, 2'h0, 8'h00, 32'h0, 1, 0);
    summarize();
  end
endmodule

`default_nettype wire
